//--- hw/alu_pkg.sv
// constants and types shared by the subtract and decrement-skip datapath
// Notes on behaviour
// [RL1] subtract with borrow: memory byte becomes accumulator minus byte minus inverted carry
// [RL2] after subtract with borrow, carry is 0 for a negative result, else 1
// [RL3] subtract with borrow updates overflow, zero, half carry, carry, signed, chained zero
// [RL4] memory decrement stores byte minus one; a zero result skips the next instruction
// [RL5] a non-zero decremented memory byte lets the next instruction run normally
// [RL6] each decrement-skip instruction occupies two instruction cycles, second is a dummy
// [RL7] accumulator decrement loads byte minus one, memory byte left untouched
// [RL8] accumulator decrement skips the next instruction when the loaded value is zero
// [RL9] both decrement forms leave every status flag unchanged
package alu_pkg;

  localparam int DATA_W = 8;
  localparam int SIGN_BIT = 7;
  localparam int NIBBLE_W = 4;
  localparam int NUM_FLAGS = 6;
  localparam int REG_ADDR_W = 2;

  // status flag bit positions
  localparam int FLAG_C = 0;
  localparam int FLAG_AC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_SC = 4;
  localparam int FLAG_CZ = 5;

  // register offsets on the plain register port
  localparam logic [REG_ADDR_W-1:0] REG_ACC = 2'h0;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 2'h1;
  localparam logic [REG_ADDR_W-1:0] REG_RESULT = 2'h2;
  localparam logic [REG_ADDR_W-1:0] REG_EXEC = 2'h3;

  // execution readback field positions
  localparam int EXEC_STATE_LSB = 0;
  localparam int EXEC_BUSY_BIT = 2;
  localparam int EXEC_SKIP_BIT = 3;

  // reset values
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [NUM_FLAGS-1:0] STATUS_RESET = 6'h00;
  localparam logic [DATA_W-1:0] RESULT_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ONE = 8'h01;

  typedef enum logic [1:0] {
    OP_SUB_BORROW_MEM = 2'h0,
    OP_DECREMENT_MEM_SKIP_ZERO = 2'h1,
    OP_DECREMENT_TO_ACC_SKIP_ZERO = 2'h2,
    OP_UNUSED = 2'h3
  } op_t;

  // gray codes along idle, fetch, execute, dummy
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b11,
    ST_DUMMY = 2'b10
  } exec_state_t;

endpackage

//--- hw/sub_borrow_calc.sv
// combinational subtract-with-borrow and its six status flags
`timescale 1ns/1ps
`default_nettype none
module sub_borrow_calc
  import alu_pkg::*;
(
  // operands
  input wire logic [DATA_W-1:0] minuend,
  input wire logic [DATA_W-1:0] subtrahend,
  input wire logic carry_in,
  input wire logic zero_in,
  // results
  output logic [DATA_W-1:0] result,
  output logic [NUM_FLAGS-1:0] flags
);

  logic [DATA_W:0] full_sum;
  logic [NIBBLE_W:0] low_sum;
  logic overflow;

  // a - b - !c is a + ~b + c; carry out set means no borrow
  always_comb begin
    full_sum = {1'b0, minuend} + {1'b0, ~subtrahend}
      + {{DATA_W{1'b0}}, carry_in}; // RL1
    low_sum = {1'b0, minuend[NIBBLE_W-1:0]}
      + {1'b0, ~subtrahend[NIBBLE_W-1:0]}
      + {{NIBBLE_W{1'b0}}, carry_in};
    result = full_sum[DATA_W-1:0];
    overflow = (minuend[SIGN_BIT] != subtrahend[SIGN_BIT])
      && (result[SIGN_BIT] != minuend[SIGN_BIT]);
    flags = '0;
    flags[FLAG_C] = full_sum[DATA_W]; // RL2
    flags[FLAG_AC] = low_sum[NIBBLE_W]; // RL3
    flags[FLAG_Z] = (result == BYTE_ZERO); // RL3
    flags[FLAG_OV] = overflow; // RL3
    flags[FLAG_SC] = result[SIGN_BIT] ^ overflow; // RL3
    // chained zero ANDs this byte's zero test with the zero flag left by the previous subtract
    flags[FLAG_CZ] = (result == BYTE_ZERO) && zero_in; // RL3
  end

endmodule
`default_nettype wire

//--- hw/sub_dec_skip_unit.sv
// datapath for subtract-with-borrow and the two decrement-skip instructions
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sub_dec_skip_unit
  import alu_pkg::*;
#(
  parameter int MEM_ADDR_W = 8
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // instruction issue from the sequencer
  input wire logic issue_valid,
  input wire logic [1:0] issue_op,
  input wire logic [MEM_ADDR_W-1:0] issue_addr,
  output logic busy_q,
  output logic done_q,
  output logic skip_q,
  output logic dummy_cycle_q,
  // data memory
  output logic mem_rd_en_q,
  output logic mem_wr_en_q,
  output logic [MEM_ADDR_W-1:0] mem_addr_q,
  output logic [DATA_W-1:0] mem_wdata_q,
  input wire logic [DATA_W-1:0] mem_rdata,
  // architectural state
  output logic [DATA_W-1:0] acc_q,
  output logic [NUM_FLAGS-1:0] flags_q,
  // register port
  input wire logic [REG_ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata_q
);

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == BYTE_ZERO;
  endfunction

  function automatic logic is_dec(input op_t op);
    return op == OP_DECREMENT_MEM_SKIP_ZERO
      || op == OP_DECREMENT_TO_ACC_SKIP_ZERO;
  endfunction

  exec_state_t state_q;
  exec_state_t state_d;
  op_t op_q;
  logic [DATA_W-1:0] result_q;
  logic last_skip_q;
  logic [DATA_W-1:0] sub_result;
  logic [NUM_FLAGS-1:0] sub_flags;
  logic [DATA_W-1:0] dec_result;
  logic in_exec;
  logic accept;

  sub_borrow_calc u_calc (
    .minuend(acc_q),
    .subtrahend(mem_rdata),
    .carry_in(flags_q[FLAG_C]),
    .zero_in(flags_q[FLAG_Z]),
    .result(sub_result),
    .flags(sub_flags)
  );

  assign dec_result = mem_rdata - BYTE_ONE;
  assign in_exec = ce && (state_q == ST_EXEC);
  assign accept = ce && (state_q == ST_IDLE) && issue_valid
    && (op_t'(issue_op) != OP_UNUSED);

  // sequencing: fetch operand, execute, then a dummy slot for both decrement-skip forms, skip or not
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (accept) begin
          state_d = ST_FETCH;
        end
      end
      ST_FETCH: begin
        state_d = ST_EXEC;
      end
      ST_EXEC: begin
        state_d = is_dec(op_q) ? ST_DUMMY : ST_IDLE; // RL6
      end
      ST_DUMMY: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // instruction capture and memory read request
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_q <= OP_SUB_BORROW_MEM;
      mem_addr_q <= '0;
      mem_rd_en_q <= 1'b0;
    end else if (ce) begin
      mem_rd_en_q <= accept;
      if (accept) begin
        op_q <= op_t'(issue_op);
        mem_addr_q <= issue_addr;
      end
    end
  end

  // handshake outputs toward the sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      dummy_cycle_q <= 1'b0;
    end else if (ce) begin
      busy_q <= state_d != ST_IDLE;
      done_q <= (state_q != ST_IDLE) && (state_d == ST_IDLE);
      dummy_cycle_q <= state_d == ST_DUMMY; // RL6
    end
  end

  // skip decision, one pulse as the dummy slot begins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      skip_q <= 1'b0;
      last_skip_q <= 1'b0;
    end else if (ce) begin
      skip_q <= 1'b0;
      if (state_q == ST_EXEC) begin
        skip_q <= is_dec(op_q) && is_zero(dec_result); // RL4 RL5 RL8
        last_skip_q <= is_dec(op_q) && is_zero(dec_result);
      end
    end
  end

  // memory write-back
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_wr_en_q <= 1'b0;
      mem_wdata_q <= BYTE_ZERO;
    end else if (ce) begin
      mem_wr_en_q <= 1'b0;
      if (state_q == ST_EXEC) begin
        unique case (op_q)
          OP_SUB_BORROW_MEM: begin
            mem_wr_en_q <= 1'b1; // RL1
            mem_wdata_q <= sub_result; // RL1
          end
          OP_DECREMENT_MEM_SKIP_ZERO: begin
            mem_wr_en_q <= 1'b1; // RL4
            mem_wdata_q <= dec_result; // RL4
          end
          default: begin
            // accumulator form leaves memory alone
            mem_wr_en_q <= 1'b0; // RL7
          end
        endcase
      end
    end
  end

  // accumulator: software write while idle, decrement-to-acc result
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      acc_q <= ACC_RESET;
    end else if (ce) begin
      if (state_q == ST_EXEC
          && op_q == OP_DECREMENT_TO_ACC_SKIP_ZERO) begin
        acc_q <= dec_result; // RL7
      end else if (state_q == ST_IDLE && reg_wr
                   && reg_addr == REG_ACC) begin
        acc_q <= reg_wdata;
      end
    end
  end

  // status flags: software write while idle, otherwise only subtract with borrow changes them
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags_q <= STATUS_RESET;
    end else if (ce) begin
      if (state_q == ST_EXEC && op_q == OP_SUB_BORROW_MEM) begin // RL9
        flags_q <= sub_flags; // RL2 RL3
      end else if (state_q == ST_IDLE && reg_wr
                   && reg_addr == REG_STATUS) begin
        flags_q <= reg_wdata[NUM_FLAGS-1:0];
      end
      // decrement forms fall through here untouched
    end
  end

  // last computed byte for readback
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      result_q <= RESULT_RESET;
    end else if (ce && state_q == ST_EXEC) begin
      unique case (op_q)
        OP_SUB_BORROW_MEM: result_q <= sub_result;
        default: result_q <= dec_result;
      endcase
    end
  end

  // register readback, valid only in the cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_q <= BYTE_ZERO;
    end else if (ce) begin
      reg_rdata_q <= BYTE_ZERO;
      if (reg_rd) begin
        unique case (reg_addr)
          REG_ACC: reg_rdata_q <= acc_q;
          REG_STATUS: reg_rdata_q <= {{(DATA_W-NUM_FLAGS){1'b0}}, flags_q};
          REG_RESULT: reg_rdata_q <= result_q;
          REG_EXEC: begin
            reg_rdata_q <= BYTE_ZERO;
            reg_rdata_q[EXEC_STATE_LSB +: 2] <= state_q;
            reg_rdata_q[EXEC_BUSY_BIT] <= busy_q;
            reg_rdata_q[EXEC_SKIP_BIT] <= last_skip_q;
          end
        endcase
      end
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_exec_sub;
    in_exec && op_q == OP_SUB_BORROW_MEM;
  endsequence

  sequence s_exec_dec;
    in_exec && is_dec(op_q);
  endsequence

  sequence s_dummy_slot;
    state_q == ST_DUMMY && dummy_cycle_q;
  endsequence

  a_sub_mem_write: assert property ( // RL1
    s_exec_sub |=> mem_wr_en_q && mem_wdata_q == $past(acc_q)
      - $past(mem_rdata) - {{(DATA_W-1){1'b0}}, !$past(flags_q[FLAG_C])})
    else $error("subtract result not written to memory");

  a_carry_sign: assert property ( // RL2
    s_exec_sub |=> flags_q[FLAG_C] == ({1'b0, $past(acc_q)} >=
      {1'b0, $past(mem_rdata)} + {{DATA_W{1'b0}}, !$past(flags_q[FLAG_C])}))
    else $error("carry does not reflect result sign");

  a_sub_zero_flags: assert property ( // RL3
    s_exec_sub |=> flags_q[FLAG_Z] == is_zero(mem_wdata_q)
      && flags_q[FLAG_CZ] == (is_zero(mem_wdata_q) && $past(flags_q[FLAG_Z]))
      && flags_q[FLAG_SC] == (mem_wdata_q[SIGN_BIT] ^ flags_q[FLAG_OV]))
    else $error("zero or signed flags wrong after subtract");

  a_dec_mem_write: assert property ( // RL4
    s_exec_dec ##0 op_q == OP_DECREMENT_MEM_SKIP_ZERO |=>
      mem_wr_en_q && mem_wdata_q == $past(mem_rdata) - BYTE_ONE
      && mem_addr_q == $past(mem_addr_q) && skip_q == is_zero(mem_wdata_q))
    else $error("memory decrement or skip wrong");

  a_dec_no_skip: assert property ( // RL5
    s_exec_dec ##0 !is_zero(dec_result) |=> !skip_q ##1 !skip_q)
    else $error("skip taken on non-zero result");

  a_dec_two_slots: assert property ( // RL6
    s_exec_dec |=> s_dummy_slot ##0 busy_q ##1 (done_q || !$past(ce)))
    else $error("decrement did not take a dummy slot");

  a_acc_dec_load: assert property ( // RL7
    s_exec_dec ##0 op_q == OP_DECREMENT_TO_ACC_SKIP_ZERO |=>
      acc_q == $past(mem_rdata) - BYTE_ONE && !mem_wr_en_q)
    else $error("accumulator decrement wrong or memory written");

  a_acc_skip: assert property ( // RL8
    s_exec_dec ##0 op_q == OP_DECREMENT_TO_ACC_SKIP_ZERO |=>
      skip_q == is_zero(acc_q))
    else $error("accumulator skip decision wrong");

  a_dec_flags_hold: assert property ( // RL9
    s_exec_dec |=> $stable(flags_q))
    else $error("decrement changed status flags");

  // operand read goes out at the issued address right after acceptance
  a_operand_read: assert property ( // RL1 RL4
    accept |=> mem_rd_en_q && busy_q && mem_addr_q == $past(issue_addr))
    else $error("operand read not requested after issue");

  a_sub_one_slot: assert property ( // RL6
    s_exec_sub |=> done_q && !busy_q && !dummy_cycle_q && !skip_q)
    else $error("subtract took a dummy slot or skipped");

  a_ce_freeze: assert property (
    !ce |=> $stable(state_q) && $stable(acc_q) && $stable(flags_q))
    else $error("state moved while clock enable low");

endmodule
`default_nettype wire

//--- verification/data_mem_model.sv
// behavioural data memory on the far side of the datapath
`timescale 1ns/1ps
`default_nettype none
module data_mem_model (
  // clock
  input wire logic sys_clk,
  // memory port
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [256];
  initial rdata = 8'h00;
  // read data is valid one cycle after the request, garbage otherwise
  always @(posedge sys_clk) begin
    if (wr_en) mem[addr] <= wdata;
    if (rd_en) rdata <= mem[addr];
    else rdata <= ~rdata;
  end
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking testbench for the subtract and decrement-skip datapath
`timescale 1ns/1ps
`default_nettype none
module tb;
  import alu_pkg::*;
  logic sys_clk, rst, ce, issue_valid, reg_wr, reg_rd;
  logic busy_q, done_q, skip_q, dummy_cycle_q, mem_rd_en_q, mem_wr_en_q;
  logic [1:0] issue_op, reg_addr;
  logic [7:0] issue_addr, reg_wdata, mem_rdata, mem_addr_q, mem_wdata_q;
  logic [DATA_W-1:0] acc_q, reg_rdata_q;
  logic [NUM_FLAGS-1:0] flags_q;
  int bad_count, n_compared, lat, bz;
  logic sk, dm;
  logic [7:0] rd, m, r;
  logic [13:0] e;
  logic [7:0] sa [4] = '{8'h50, 8'h20, 8'h20, 8'h80};
  logic [7:0] sm [4] = '{8'h20, 8'h20, 8'h1f, 8'h01};
  logic [5:0] ss [4] = '{6'h01, 6'h00, 6'h04, 6'h01};
  logic [1:0] dop [4] = '{2'h1, 2'h1, 2'h2, 2'h2};
  logic [7:0] dmv [4] = '{8'h01, 8'h00, 8'h01, 8'h80};

  sub_dec_skip_unit #(.MEM_ADDR_W(8)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .issue_valid(issue_valid), .issue_op(issue_op),
    .issue_addr(issue_addr), .busy_q(busy_q), .done_q(done_q),
    .skip_q(skip_q), .dummy_cycle_q(dummy_cycle_q),
    .mem_rd_en_q(mem_rd_en_q), .mem_wr_en_q(mem_wr_en_q),
    .mem_addr_q(mem_addr_q), .mem_wdata_q(mem_wdata_q),
    .mem_rdata(mem_rdata), .acc_q(acc_q), .flags_q(flags_q),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q)
  );

  data_mem_model i_mem (
    .sys_clk(sys_clk), .rd_en(mem_rd_en_q), .wr_en(mem_wr_en_q),
    .addr(mem_addr_q), .wdata(mem_wdata_q), .rdata(mem_rdata)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata_q;
  endtask

  // issue one instruction, then watch until done for at most 8 cycles
  task automatic run_op(input logic [1:0] op, input logic [7:0] a);
    @(posedge sys_clk);
    issue_valid <= 1'b1;
    issue_op <= op;
    issue_addr <= a;
    @(posedge sys_clk);
    issue_valid <= 1'b0;
    lat = 0;
    bz = 0;
    sk = 1'b0;
    dm = 1'b0;
    for (int k = 1; k <= 8 && lat == 0; k++) begin
      @(negedge sys_clk);
      if (busy_q === 1'b1) bz++;
      if (skip_q === 1'b1) sk = 1'b1;
      if (dummy_cycle_q === 1'b1) dm = 1'b1;
      if (done_q === 1'b1) lat = k;
    end
  endtask

  // expected flags and result of subtract with borrow
  function automatic logic [13:0] sub_exp(input logic [7:0] a, b,
                                          input logic [5:0] st);
    logic [8:0] d;
    logic [4:0] h;
    logic [5:0] f;
    f = 6'h00;
    d = {1'b0, a} - {1'b0, b} - 9'(!st[FLAG_C]);
    h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - 5'(!st[FLAG_C]);
    f[FLAG_C] = ~d[8];
    f[FLAG_AC] = ~h[4];
    f[FLAG_Z] = (d[7:0] == 8'h00);
    f[FLAG_OV] = (a[7] != b[7]) && (d[7] != a[7]);
    f[FLAG_SC] = d[7] ^ f[FLAG_OV];
    f[FLAG_CZ] = f[FLAG_Z] & st[FLAG_Z];
    return {f, d[7:0]};
  endfunction

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #(100 * 4000);
    bad_count++;
    give_verdict();
  end

  initial begin
    bad_count = 0;
    n_compared = 0;
    rst = 1'b1;
    ce = 1'b1;
    issue_valid = 1'b0;
    issue_op = 2'h0;
    issue_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      reg_read(2'(i), rd);
      chk("reset value", 8'h00, rd);
    end
    for (int i = 0; i < 4; i++) begin
      reg_write(REG_ACC, sa[i]);
      reg_write(REG_STATUS, {2'b00, ss[i]});
      i_mem.mem[8'h10 + i] = sm[i];
      e = sub_exp(sa[i], sm[i], ss[i]);
      run_op(2'h0, 8'h10 + 8'(i));
      // the write-back lands in memory one edge after done
      @(negedge sys_clk);
      chk("sub result", e[7:0], i_mem.mem[8'h10 + i]);
      chk("sub flags", {2'b00, e[13:8]}, {2'b00, flags_q});
      chk("sub done", 8'h03, 8'(lat));
      chk("sub busy", 8'h02, 8'(bz));
    end
    reg_write(REG_STATUS, 8'h2a);
    for (int i = 0; i < 4; i++) begin
      m = dmv[i];
      r = m - 8'h01;
      i_mem.mem[8'h20 + i] = m;
      run_op(dop[i], 8'h20 + 8'(i));
      if (dop[i] == 2'h1) begin
        chk("dec mem", r, i_mem.mem[8'h20 + i]);
      end else begin
        chk("dec acc", r, acc_q);
        chk("dec acc mem", m, i_mem.mem[8'h20 + i]);
      end
      chk("skip", {7'h00, r == 8'h00}, {7'h00, sk});
      chk("dec done", 8'h04, 8'(lat));
      chk("dec busy", 8'h03, 8'(bz));
      chk("dummy", 8'h01, {7'h00, dm});
      chk("flags kept", 8'h2a, {2'b00, flags_q});
    end
    reg_read(REG_ACC, rd);
    chk("acc read", 8'h7f, rd);
    run_op(2'h1, 8'h22);
    chk("dec mem again", 8'h00, i_mem.mem[8'h22]);
    reg_read(REG_EXEC, rd);
    chk("exec readback", 8'h08, rd);
    reg_read(REG_RESULT, rd);
    chk("result readback", 8'h00, rd);
    // a write while the clock enable is low must not land
    @(posedge sys_clk);
    ce <= 1'b0;
    reg_write(REG_ACC, 8'h55);
    ce <= 1'b1;
    reg_read(REG_ACC, rd);
    chk("acc frozen", 8'h7f, rd);
    run_op(2'h3, 8'h30);
    chk("op 3 ignored", 8'h00, 8'(lat));
    chk("op 3 busy", 8'h00, 8'(bz));
    give_verdict();
  end
endmodule
`default_nettype wire
